/* File: hw/clp_defines.svh */
/*
 * Constants of the cascaded LED PWM shift block: packet layout,
 * reset values, timing figures and register offsets.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef CLP_DEFINES_SVH
`define CLP_DEFINES_SVH

// ----------------------------------------
// Packet layout
// ----------------------------------------
`define CLP_SHIFT_W 224
`define CLP_LATCH_W 218
`define CLP_CMD_W 6
`define CLP_CMD_WRITE 6'h25
`define CLP_CH_N 12
`define CLP_GRAY_W 16
`define CLP_BLANK_BIT 213
`define CLP_REPEAT_BIT 214
`define CLP_RESTART_BIT 215
`define CLP_EXTSEL_BIT 216
`define CLP_LATCH_RST 218'h0
`define CLP_PERIOD_END 17'h10000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLP_CLK_NS 100
`define CLP_IDLE_MULT 3
`define CLP_IDLE_MIN_NS 666
`define CLP_IDLE_MAX_NS 2740000
`define CLP_IDLE_MIN_CYC ((`CLP_IDLE_MIN_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)
`define CLP_IDLE_MAX_CYC (`CLP_IDLE_MAX_NS / `CLP_CLK_NS)

// ----------------------------------------
// Registers
// ----------------------------------------
`define CLP_REG_CTRL 32'h00
`define CLP_REG_STATUS 32'h04
`define CLP_REG_GSCNT 32'h08
`define CLP_REG_LOG 32'h0c
`define CLP_CTRL_RST 2'h1
`define CLP_OVF_BIT 5

`endif

/* File: hw/clp_pkg.sv */
/*
 * Types shared by the cascaded LED PWM shift block.
 * Assumes clp_defines.svh is on the include path.
 */
`include "clp_defines.svh"

package clp_pkg;

    // Control bits taken from a latched packet
    typedef struct packed {
        logic ext_sel;
        logic repeat_en;
        logic restart_en;
        logic blank;
    } clp_ctl_type;

    // One entry of the latch event log
    typedef struct packed {
        logic [20:0] rsvd;
        logic accepted;
        logic [5:0] command;
        clp_ctl_type ctl;
    } clp_log_type;

endpackage

/* File: hw/clp_top.sv */
/*
 * Cascaded LED PWM shift control: serial shift-in, idle-detect latch,
 * shift-clock driven grayscale PWM, AHB-Lite status and latch log.
 * Assumes one AHB-Lite master, hclk at 10 MHz, and shift_clock_in and
 * serial_data_in arriving asynchronously from the host controller.
 */
// Register access over AHB-Lite and the address map were chosen for this implementation.
// Behaviour
// - Blanking resets to one; all sinks stay off until a packet clears it.
// - With timing restart set in the incoming packet, PWM timing restarts at a latch pulse whose command is accepted.
// - PWM runs only once blanking is latched as zero.
// - Shift clock static for eight last periods is the latch condition.
// - Latch copies the 218 low shift bits into the data latch.
// - Idle threshold scales with period, clamped 666 ns to 2.74 ms.
// - PWM keeps counting on the clocks that shift the next data in.
// - A display period ends after 65536 grayscale reference clocks.
// - Shift clock is both PWM reference and data shift clock.
// - Latch copy happens only when the six command bits equal 25h.
// - At the first reference clock nonzero-valued outputs switch on.
`timescale 1ns/100ps
`default_nettype none
`include "clp_defines.svh"

// ----------------------------------------
// Log FIFO
// ----------------------------------------
module clp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign in_ready = (wr_ptr_ff != {~rd_ptr_ff[AW], rd_ptr_ff[AW-1:0]});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule // clp_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module clp_top #(
    parameter int IDLE_MAX_CYC = `CLP_IDLE_MAX_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic shift_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic [`CLP_CH_N-1:0] led_sink_output,
    input wire clp_pkg::clp_ctl_type unused_ctl_probe
);
    import clp_pkg::*;

    function automatic logic agree(input logic [2:0] s);
        agree = (s[1] == s[2]);
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] sck_sync_ff;
    logic [2:0] sdi_sync_ff;
    logic sck_lvl_ff;
    logic sdi_lvl_ff;
    logic sck_rise;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_sync_ff <= 3'h0;
            sdi_sync_ff <= 3'h0;
            sck_lvl_ff <= 1'b0;
            sdi_lvl_ff <= 1'b0;
        end else begin
            sck_sync_ff <= {sck_sync_ff[1:0], shift_clock_in};
            sdi_sync_ff <= {sdi_sync_ff[1:0], serial_data_in};
            if (agree(sck_sync_ff)) begin
                sck_lvl_ff <= sck_sync_ff[2];
            end
            if (agree(sdi_sync_ff)) begin
                sdi_lvl_ff <= sdi_sync_ff[2];
            end
        end
    end

    // One rising edge of the shift clock as seen after filtering
    assign sck_rise = agree(sck_sync_ff) & sck_sync_ff[2] & ~sck_lvl_ff;

    // ----------------------------------------
    // Shift register and chain output
    // ----------------------------------------
    logic [`CLP_SHIFT_W-1:0] shift_ff;
    logic sdo_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_ff <= '0;
            sdo_ff <= 1'b0;
        end else if (sck_rise) begin
            sdo_ff <= shift_ff[`CLP_SHIFT_W-1];
            shift_ff <= {shift_ff[`CLP_SHIFT_W-2:0], sdi_lvl_ff};
        end
    end

    assign serial_data_out = sdo_ff;

    // ----------------------------------------
    // Period measurement and idle detection
    // ----------------------------------------
    logic [23:0] since_ff;
    logic [23:0] period_ff;
    logic [1:0] edges_ff;
    logic shifted_ff;
    logic [26:0] thr_raw;
    logic [23:0] thr;
    logic latch_pulse;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_ff <= 24'h0;
            period_ff <= 24'h0;
            edges_ff <= 2'h0;
        end else if (sck_rise) begin
            since_ff <= 24'h1;
            period_ff <= since_ff;
            if (edges_ff != 2'h2) begin
                edges_ff <= edges_ff + 2'h1;
            end
        end else if (since_ff != 24'hffffff) begin
            since_ff <= since_ff + 24'h1;
        end
    end

    // The threshold follows the last measured period, so a slow host simply waits
    // longer; the clamp keeps a glitchy period from latching too early or never.
    always_comb begin
        thr_raw = {period_ff, 3'h0};
        if (thr_raw < 27'(`CLP_IDLE_MIN_CYC)) begin
            thr = 24'(`CLP_IDLE_MIN_CYC);
        end else if (thr_raw > 27'(IDLE_MAX_CYC)) begin
            thr = 24'(IDLE_MAX_CYC);
        end else begin
            thr = thr_raw[23:0];
        end
    end

    assign latch_pulse = shifted_ff & (edges_ff == 2'h2) & ~sck_rise & (since_ff >= thr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shifted_ff <= 1'b0;
        end else if (sck_rise) begin
            shifted_ff <= 1'b1;
        end else if (latch_pulse) begin
            shifted_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Data latch
    // ----------------------------------------
    logic [`CLP_LATCH_W-1:0] latch_ff;
    logic cmd_ok;
    clp_ctl_type ctl;

    assign cmd_ok = (shift_ff[`CLP_SHIFT_W-1 -: `CLP_CMD_W] == `CLP_CMD_WRITE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_ff <= `CLP_LATCH_RST | (218'h1 << `CLP_BLANK_BIT);
        end else if (latch_pulse && cmd_ok) begin
            latch_ff <= shift_ff[`CLP_LATCH_W-1:0];
        end
    end

    assign ctl.ext_sel = latch_ff[`CLP_EXTSEL_BIT];
    assign ctl.repeat_en = latch_ff[`CLP_REPEAT_BIT];
    assign ctl.restart_en = latch_ff[`CLP_RESTART_BIT];
    assign ctl.blank = latch_ff[`CLP_BLANK_BIT];

    // ----------------------------------------
    // Grayscale counter
    // ----------------------------------------
    // Counts reference clocks received in the current period; 0 means none yet.
    logic [16:0] gray_cnt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gray_cnt_ff <= 17'h0;
        end else if (latch_pulse && cmd_ok && shift_ff[`CLP_RESTART_BIT]) begin
            gray_cnt_ff <= 17'h0;
        end else if (sck_rise && ctl.ext_sel && !ctl.blank) begin
            if (gray_cnt_ff != `CLP_PERIOD_END) begin
                gray_cnt_ff <= gray_cnt_ff + 17'h1;
            end else if (ctl.repeat_en) begin
                gray_cnt_ff <= 17'h1;
            end
        end
    end

    // ----------------------------------------
    // Sink outputs
    // ----------------------------------------
    logic [1:0] ctrl_ff;
    logic [`CLP_CH_N-1:0] out_ff;
    logic [16:0] phase;

    assign phase = gray_cnt_ff - 17'h1;

    genvar ch;
    generate
        for (ch = 0; ch < `CLP_CH_N; ch++) begin : g_ch
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_ff[ch] <= 1'b0;
                end else if (ctl.blank || ctrl_ff[1] || gray_cnt_ff == 17'h0) begin
                    out_ff[ch] <= 1'b0;
                end else begin
                    // The end of period is reached when phase hits 65535
                    out_ff[ch] <= phase < {1'b0, latch_ff[ch*`CLP_GRAY_W +: `CLP_GRAY_W]};
                end
            end
        end
    endgenerate

    assign led_sink_output = out_ff;

    // ----------------------------------------
    // Latch event log
    // ----------------------------------------
    // A pending slot holds one event while the FIFO is full; a second event
    // arriving meanwhile is dropped and flagged, since the link cannot stall.
    clp_log_type ev;
    clp_log_type pend_ff;
    clp_log_type head;
    logic pend_vld_ff;
    logic fifo_ready;
    logic fifo_valid;
    logic pop;
    logic ovf_ff;
    logic ovf_clr;
    logic log_evt;

    always_comb begin
        ev = '0;
        ev.accepted = cmd_ok;
        ev.command = shift_ff[`CLP_SHIFT_W-1 -: `CLP_CMD_W];
        ev.ctl.ext_sel = shift_ff[`CLP_EXTSEL_BIT];
        ev.ctl.repeat_en = shift_ff[`CLP_REPEAT_BIT];
        ev.ctl.restart_en = shift_ff[`CLP_RESTART_BIT];
        ev.ctl.blank = shift_ff[`CLP_BLANK_BIT];
    end

    assign log_evt = latch_pulse & ctrl_ff[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_vld_ff <= 1'b0;
            pend_ff <= '0;
        end else if (log_evt && (!pend_vld_ff || fifo_ready)) begin
            pend_vld_ff <= 1'b1;
            pend_ff <= ev;
        end else if (fifo_ready) begin
            pend_vld_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_ff <= 1'b0;
        end else if (log_evt && pend_vld_ff && !fifo_ready) begin
            ovf_ff <= 1'b1;
        end else if (ovf_clr) begin
            ovf_ff <= 1'b0;
        end
    end

    clp_fifo #(
        .WIDTH(32),
        .DEPTH(16)
    ) u_log (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(pend_vld_ff),
        .in_ready(fifo_ready),
        .in_data(pend_ff),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(head)
    );

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic take;
    logic wr_ff;
    logic [31:0] addr_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    assign take = hsel & htrans[1] & hready;
    assign pop = take & ~hwrite & (haddr == `CLP_REG_LOG) & fifo_valid;
    assign ovf_clr = wr_ff & (addr_ff == `CLP_REG_STATUS) & hwdata[`CLP_OVF_BIT];

    always_comb begin
        if (haddr == `CLP_REG_CTRL) begin
            nxt_rdata = {30'h0, ctrl_ff};
        end else if (haddr == `CLP_REG_STATUS) begin
            nxt_rdata = {26'h0, ovf_ff, fifo_valid, ctl};
        end else if (haddr == `CLP_REG_GSCNT) begin
            nxt_rdata = {15'h0, gray_cnt_ff};
        end else if (haddr == `CLP_REG_LOG) begin
            nxt_rdata = fifo_valid ? head : 32'h0;
        end else begin
            nxt_rdata = 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            addr_ff <= 32'h0;
            rdata_ff <= 32'h0;
        end else begin
            wr_ff <= take & hwrite;
            if (take) begin
                addr_ff <= haddr;
            end
            if (take && !hwrite) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `CLP_CTRL_RST;
        end else if (wr_ff && addr_ff == `CLP_REG_CTRL) begin
            ctrl_ff <= hwdata[1:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

endmodule // clp_top
`default_nettype wire

/* File: testbench/clp_host_model.sv */
/* Host controller model: shift clock and serial data.
 * Assumes a caller that sequences bits and idle gaps on hclk. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host
// ----------------------------------------
module clp_host_model (
    input wire logic hclk,
    output logic shift_clock_in,
    output logic serial_data_in
);
    initial begin
        shift_clock_in = 1'b0;
        serial_data_in = 1'b0;
    end
    // One 800 ns period: data one cycle ahead of the rise, held to the next bit
    task automatic bit_out(input logic b);
        @(posedge hclk);
        serial_data_in <= b;
        @(posedge hclk);
        shift_clock_in <= 1'b1;
        repeat (4) @(posedge hclk);
        shift_clock_in <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    // Clock held low; data released, so it shows the inverse of its last value
    task automatic idle(input int n);
        @(posedge hclk);
        serial_data_in <= ~serial_data_in;
        repeat (n) @(posedge hclk);
    endtask
endmodule // clp_host_model
`default_nettype wire

/* File: testbench/clp_top_sva.sv */
/* Port checker for the LED PWM shift block.
 * Assumes hclk at 10 MHz and a host shift clock near 800 ns. */
`timescale 1ns/100ps
`default_nettype none
`include "clp_defines.svh"
// ----------------------------------------
// Checker
// ----------------------------------------
module clp_top_sva #(
    parameter int IDLE_MAX_CYC = `CLP_IDLE_MAX_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic shift_clock_in,
    input wire logic serial_data_out,
    input wire logic [`CLP_CH_N-1:0] led_sink_output
);
    logic rd_c;
    logic sck_q_ff;
    logic [7:0] since_ff;
    assign rd_c = hsel && htrans[1] && hready && !hwrite;
    // Cycles since the pin rose; saturates so long idles never wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_q_ff <= 1'b0;
            since_ff <= 8'hff;
        end else begin
            sck_q_ff <= shift_clock_in;
            if (shift_clock_in && !sck_q_ff)
                since_ff <= 8'h00;
            else if (since_ff != 8'hff)
                since_ff <= since_ff + 8'h01;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_LEDS_OFF_AT_RESET: assert property (
        $rose(hresetn) |-> (led_sink_output == '0) [*3]) else $error("sinks on after reset");
    AST_LED_ON_NEEDS_CLOCK: assert property (
        |(led_sink_output & ~$past(led_sink_output)) |-> since_ff <= 8'h08)
        else $error("sink switched on without a reference clock");
    AST_SDO_FOLLOWS_SHIFT: assert property (
        $changed(serial_data_out) |-> since_ff <= 8'h08) else $error("serial out moved alone");
    AST_SDO_QUIET_IDLE: assert property (
        $stable(shift_clock_in) [*8] |=> $stable(serial_data_out))
        else $error("serial out moved while clock idle");
    AST_GSCNT_BOUND: assert property (
        rd_c && haddr == `CLP_REG_GSCNT |=> hrdata <= {15'h0, `CLP_PERIOD_END})
        else $error("period counter past its end");
    AST_UNMAPPED_ZERO: assert property (
        rd_c && haddr[7:0] > 8'h0c |=> hrdata == 32'h0) else $error("unmapped read not zero");
    AST_READ_HOLD: assert property (
        !rd_c |=> $stable(hrdata)) else $error("read data moved without a read");
    AST_ZERO_WAIT: assert property (
        hreadyout == 1'b1) else $error("wait state inserted");
    AST_OKAY: assert property (
        hresp == 1'b0) else $error("error response");
    COV_LED_ON: cover property ($rose(led_sink_output[1]));
    COV_SDO_MOVES: cover property ($changed(serial_data_out));
    COV_GSCNT_READ: cover property (rd_c && haddr == `CLP_REG_GSCNT);
endmodule // clp_top_sva

bind clp_top clp_top_sva #(.IDLE_MAX_CYC(IDLE_MAX_CYC)) clp_top_sva_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .shift_clock_in(shift_clock_in), .serial_data_out(serial_data_out),
    .led_sink_output(led_sink_output));
`default_nettype wire

/* File: testbench/clp_top_tb_top.sv */
/* Self-checking bench for the LED PWM shift block.
 * Assumes clp_top, clp_host_model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "clp_defines.svh"
// ----------------------------------------
// Bench
// ----------------------------------------
module clp_top_tb_top;
    import clp_pkg::*;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, rd_phase, act;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata;
    wire logic hreadyout, hresp, serial_data_out, sck, sdi;
    wire logic [31:0] hrdata;
    wire logic [11:0] led_sink_output;
    logic [31:0] exp_q[$];
    logic [223:0] sr_m, pk;
    logic [15:0] gval[12];
    int n_mismatch = 0;
    int comparisons = 0;
    int nb = 0;
    int n_ref = 0;
    always #50 hclk = ~hclk;
    clp_top #(.IDLE_MAX_CYC(200)) clp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .shift_clock_in(sck), .serial_data_in(sdi), .serial_data_out(serial_data_out),
        .led_sink_output(led_sink_output), .unused_ctl_probe(clp_ctl_type'(4'h0)));
    clp_host_model clp_host_model_i (.hclk(hclk), .shift_clock_in(sck), .serial_data_in(sdi));
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data are judged by the monitor at the data-phase edge
    always @(posedge hclk) begin
        if (rd_phase && hreadyout)
            chk("hrdata", exp_q.pop_front(), hrdata);
    end
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_phase <= !wr;
        if (!wr)
            exp_q.push_back(d);
        do @(posedge hclk); while (!hreadyout);
        rd_phase <= 1'b0;
    endtask
    task automatic clk_bit(input logic b);
        logic [11:0] e;
        clp_host_model_i.bit_out(b);
        if (act)
            n_ref++;
        @(negedge hclk);
        if (nb >= 224)
            chk("serial_data_out", {31'h0, sr_m[223]}, {31'h0, serial_data_out});
        sr_m = {sr_m[222:0], b};
        nb++;
        for (int k = 0; k < 12; k++)
            e[k] = act && n_ref >= 1 && n_ref - 1 < gval[k];
        chk("led_sink_output", {20'h0, e}, {20'h0, led_sink_output});
    endtask
    task automatic send_pkt(input logic [223:0] p, input int pause_at);
        for (int i = 223; i >= 0; i--) begin
            clk_bit(p[i]);
            if (i == pause_at)
                clp_host_model_i.idle(40);
        end
        clp_host_model_i.idle(100);
    endtask
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, rd_phase, act} = 4'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        void'($urandom(32'h9efa));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `CLP_REG_STATUS, 32'h1);
        ahb(1'b0, `CLP_REG_CTRL, 32'h1);
        ahb(1'b1, 32'h10, 32'hffff_ffff);
        ahb(1'b0, 32'h10, 32'h0);
        gval[0] = 16'h0;
        gval[1] = 16'hffff;
        for (int k = 2; k < 12; k++)
            gval[k] = 16'($urandom_range(8, 0));
        pk = '0;
        pk[223:218] = `CLP_CMD_WRITE;
        pk[`CLP_EXTSEL_BIT] = 1'b1;
        pk[`CLP_RESTART_BIT] = 1'b1;
        for (int k = 0; k < 12; k++)
            pk[16*k +: 16] = gval[k];
        send_pkt(pk, 100);
        act = 1'b1;
        ahb(1'b0, `CLP_REG_STATUS, 32'h1a);
        ahb(1'b0, `CLP_REG_LOG, 32'h65a);
        ahb(1'b0, `CLP_REG_LOG, 32'h0);
        repeat (8) clk_bit(1'b0);
        pk = '0;
        pk[223:218] = 6'h15;
        send_pkt(pk, -1);
        ahb(1'b0, `CLP_REG_GSCNT, 32'he8);
        ahb(1'b0, `CLP_REG_STATUS, 32'h1a);
        ahb(1'b0, `CLP_REG_LOG, 32'h150);
        ahb(1'b1, `CLP_REG_CTRL, 32'h3);
        repeat (3) @(posedge hclk);
        chk("forced off", 32'h0, {20'h0, led_sink_output});
        ahb(1'b0, `CLP_REG_CTRL, 32'h3);
        test_done();
    end
    // Expected run is under 0.6 ms
    initial begin
        #2_000_000;
        n_mismatch++;
        test_done();
    end
endmodule // clp_top_tb_top
`default_nettype wire
